/* File: bench/tb.sv */
// Self-checking bench for the phase comparator with two oscillator models.
// Assumes the reference tick every 125 cycles when REF_HZ is 1 MHz.
`timescale 1ns/100ps
`default_nettype none

module tb;
  import pll_pkg::*;
  localparam int REF_HZ  = 1_000_000;
  localparam int REF_DIV = MCLK_HZ / REF_HZ;

  logic       mclk;
  logic       rst;
  logic       fm;
  logic       am;
  logic [7:0] fm_per;
  logic [7:0] am_per;
  logic       oa;
  logic       oa_oe;
  logic       ob;
  logic       ob_oe;
  logic [7:0] lfsr;
  synth_cfg_s cfg;
  synth_cfg_s c;
  int         err_count;
  int         checks;
  int         cyc = 0;

  vco_model fm_vco (.mclk(mclk), .rst(rst), .period(fm_per), .osc(fm));
  vco_model am_vco (.mclk(mclk), .rst(rst), .period(am_per), .osc(am));

  pll_phase_comparator #(.REF_HZ(REF_HZ)) uut (
    .mclk(mclk), .rst(rst), .fm_osc_input(fm), .am_osc_input(am), .cfg(cfg),
    .phase_error_out_a(oa), .phase_error_out_a_oe(oa_oe),
    .phase_error_out_b(ob), .phase_error_out_b_oe(ob_oe));

  // ************************************************************
  // Clock, timeout and helpers
  // ************************************************************
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Hang guard, about 36000 cycles above the longest run of all 21 run calls
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      err_count++;
      final_report();
    end
  end

  function automatic int dir(synth_cfg_s k, int pf, int pa);
    int r;
    r = (k.osc_sel == OSC_SEL_AM && k.am_direct) ? k.main_div
        : k.main_div * k.prescale + k.swallow;
    r = r * ((k.osc_sel == OSC_SEL_AM) ? pa : pf);
    return (r < REF_DIV) ? 1 : (r > REF_DIV) ? 0 : 2;
  endfunction

  // Eight-bit maximal-length shift register step
  function automatic logic [7:0] lfsr_next(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic final_report();
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic compare(int got, int exp, string msg);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask

  // Settle, then tally driven levels; 1 fast, 0 slow, 2 matched
  task automatic run(synth_cfg_s k, logic [7:0] pf, logic [7:0] pa);
    int hi, lo, fl, df, e;
    hi = 0;
    lo = 0;
    fl = 0;
    df = 0;
    e = dir(k, pf, pa);
    @(negedge mclk);
    cfg = k;
    fm_per = pf;
    am_per = pa;
    repeat (1500) @(negedge mclk);
    repeat (1500) begin
      @(negedge mclk);
      if (oa_oe === 1'b1 && oa === 1'b1) hi++;
      if (oa_oe === 1'b1 && oa === 1'b0) lo++;
      if (oa_oe === 1'b0) fl++;
      if ({oa, oa_oe} !== {ob, ob_oe}) df++;
    end
    compare(df, 0, "pins differ");
    if (e != 2) compare(e ? lo : hi, 0, "opposite level");
    compare(int'((e == 1 ? hi : e == 0 ? lo : fl) > 0), 1, "state missing");
    if (e == 2) compare(int'(hi == 0 || lo == 0), 1, "matched mixes levels");
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    cfg = '0;
    fm_per = 8'h14;
    am_per = 8'h14;
    err_count = 0;
    checks = 0;
    lfsr = 8'h18;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    compare(int'({oa_oe, ob_oe} === 2'b00), 1, "reset float");
    run('{OSC_SEL_FM, 1'b1, 6'h04, 16'h0004, 7'h01}, 8'h0a, 8'h08);
    run('{OSC_SEL_AM, 1'b1, 6'h04, 16'h0004, 7'h01}, 8'h3c, 8'h0a);
    run('{OSC_SEL_AM, 1'b0, 6'h04, 16'h0004, 7'h01}, 8'h08, 8'h0a);
    run('{OSC_SEL_AM, 1'b1, 6'h02, 16'h0005, 7'h01}, 8'h09, 8'h19);
    run('{OSC_SEL_FM, 1'b0, 6'h02, 16'h0002, 7'h01}, 8'h19, 8'h09);
    // Random mix; the guard passes every draw, near-match ratios included, so all 16 run
    repeat (16) begin
      lfsr = lfsr_next(lfsr);
      c = '{lfsr[0], lfsr[1], 6'h02 + lfsr[3:2], 16'h0002 + lfsr[7:4], {6'h00, lfsr[2]}};
      lfsr = lfsr_next(lfsr);
      if (dir(c, 8 + lfsr[3:0], 8 + lfsr[7:4]) == 1
          || dir(c, 16 + lfsr[3:0], 16 + lfsr[7:4]) == 0) begin
        run(c, 8'h08 + lfsr[3:0], 8'h08 + lfsr[7:4]);
      end
    end
    final_report();
  end
endmodule // tb
`default_nettype wire

/* File: bench/vco_model.sv */
// Behavioural oscillator standing beyond the error pins, open loop.
// Assumes the bench sets its period in mclk cycles, 8 or more.
`timescale 1ns/100ps
`default_nettype none

module vco_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Control and oscillator output
  input  wire logic [7:0] period,
  output logic            osc
);
  logic [7:0] cnt;

  // Falling-edge square wave, so the comparator sees it off its own edge
  always @(negedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      osc <= 1'b0;
    end else begin
      cnt <= (cnt + 8'h01 >= period) ? 8'h00 : cnt + 8'h01;
      osc <= (cnt < (period >> 1));
    end
  end
endmodule // vco_model
`default_nettype wire

/* File: rtl/pll_phase_comparator.sv */
// Programmable divider and phase comparator of the tuning synthesizer.
// Assumes oscillator inputs are asynchronous square waves well below mclk/4,
// and that the error pins are resolved to a wire outside from out and oe.
`timescale 1ns/100ps
`default_nettype none

module pll_phase_comparator
  import pll_pkg::*;
#(
  parameter int REF_HZ = pll_pkg::REF_HZ_DEF
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Oscillator pins
  input  wire logic              fm_osc_input,
  input  wire logic              am_osc_input,
  // Configuration from the control logic
  input  wire pll_pkg::synth_cfg_s cfg,
  // Three-state error pins
  output logic                   phase_error_out_a,
  output logic                   phase_error_out_a_oe,
  output logic                   phase_error_out_b,
  output logic                   phase_error_out_b_oe
);
  import pll_pkg::*;

  localparam int REF_DIV = MCLK_HZ / REF_HZ;
  localparam logic [REF_W-1:0] REF_LAST = REF_W'(REF_DIV - 1);

  // ************************************************************
  // Pin synchronisers and edge detect
  // ************************************************************
  logic [1:0] fm_sync;
  logic [1:0] am_sync;
  logic       fm_prev;
  logic       am_prev;
  logic       fm_edge;
  logic       am_edge;
  logic       osc_edge;
  logic       swallow_mode;

  // Second flop feeds the edge detector; first flop feeds only the second
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fm_sync <= 2'h0;
      am_sync <= 2'h0;
      fm_prev <= 1'b0;
      am_prev <= 1'b0;
    end else begin
      fm_sync <= {fm_sync[0], fm_osc_input};
      am_sync <= {am_sync[0], am_osc_input};
      fm_prev <= fm_sync[1];
      am_prev <= am_sync[1];
    end
  end

  always_comb begin
    fm_edge = fm_sync[1] & ~fm_prev;
    am_edge = am_sync[1] & ~am_prev;
    // Configured input choice
    osc_edge = (cfg.osc_sel == OSC_SEL_AM) ? am_edge : fm_edge;
    // FM has no direct path; AM follows its method bit
    swallow_mode = (cfg.osc_sel == OSC_SEL_FM) | ~cfg.am_direct;
  end

  // ************************************************************
  // Programmable divider
  // ************************************************************
  logic [PRE_W-1:0]     pre_cnt;
  logic [PRE_W-1:0]     next_pre_cnt;
  logic [DIV_W-1:0]     main_cnt;
  logic [DIV_W-1:0]     next_main_cnt;
  logic [SWALLOW_W-1:0] sw_left;
  logic [SWALLOW_W-1:0] next_sw_left;
  logic                 div_pulse;
  logic                 next_div_pulse;
  logic [PRE_W-1:0]     pre_last;
  logic                 main_last;

  // Prescaler runs at P+1 until A swallows are spent, then at P
  always_comb begin
    pre_last       = (sw_left != SW_ZERO) ? cfg.prescale : (cfg.prescale - PRE_ONE);
    main_last      = (main_cnt >= (cfg.main_div - DIV_ONE));
    next_pre_cnt   = pre_cnt;
    next_main_cnt  = main_cnt;
    next_sw_left   = sw_left;
    next_div_pulse = 1'b0;
    if (osc_edge) begin
      if (!swallow_mode) begin
        // Direct division by N on every input edge
        if (main_last) begin
          next_main_cnt  = DIV_ZERO;
          next_div_pulse = 1'b1;
        end else begin
          next_main_cnt = main_cnt + DIV_ONE;
        end
        next_pre_cnt = PRE_ZERO;
        next_sw_left = cfg.swallow;
      end else if (pre_cnt >= pre_last) begin
        next_pre_cnt = PRE_ZERO;
        if (sw_left != SW_ZERO) begin
          next_sw_left = sw_left - SW_ONE;
        end
        if (main_last) begin
          // Total ratio N*P + A, swallow count reloads per cycle
          next_main_cnt  = DIV_ZERO;
          next_sw_left   = cfg.swallow;
          next_div_pulse = 1'b1;
        end else begin
          next_main_cnt = main_cnt + DIV_ONE;
        end
      end else begin
        next_pre_cnt = pre_cnt + PRE_ONE;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre_cnt   <= PRE_ZERO;
      main_cnt  <= DIV_ZERO;
      sw_left   <= SW_ZERO;
      div_pulse <= 1'b0;
    end else begin
      pre_cnt   <= next_pre_cnt;
      main_cnt  <= next_main_cnt;
      sw_left   <= next_sw_left;
      div_pulse <= next_div_pulse;
    end
  end

  // ************************************************************
  // Reference divider
  // ************************************************************
  logic [REF_W-1:0] ref_cnt;
  logic [REF_W-1:0] next_ref_cnt;
  logic             ref_pulse;
  logic             next_ref_pulse;

  // Free-running tick at the reference rate, one cycle wide
  always_comb begin
    next_ref_pulse = (ref_cnt == REF_LAST);
    next_ref_cnt   = next_ref_pulse ? REF_ZERO : (ref_cnt + REF_ONE);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ref_cnt   <= REF_ZERO;
      ref_pulse <= 1'b0;
    end else begin
      ref_cnt   <= next_ref_cnt;
      ref_pulse <= next_ref_pulse;
    end
  end

  // ************************************************************
  // Phase-frequency detector and three-state outputs
  // ************************************************************
  pd_state_e state;
  pd_state_e next_state;
  logic      err_level;
  logic      next_err_level;
  logic      err_drive;
  logic      next_err_drive;

  // Whichever edge arrives first holds the state until the other one arrives alone;
  // coincident edges in the match state keep it matched, so the pins float.
  always_comb begin
    next_state = state;
    case (state)
      PD_MATCH: begin
        if (div_pulse && !ref_pulse) begin
          next_state = PD_LEAD;
        end else if (ref_pulse && !div_pulse) begin
          next_state = PD_LAG;
        end
      end
      PD_LEAD: begin
        if (ref_pulse && !div_pulse) begin
          next_state = PD_MATCH;
        end
      end
      PD_LAG: begin
        if (div_pulse && !ref_pulse) begin
          next_state = PD_MATCH;
        end
      end
      default: begin
        next_state = PD_MATCH;
      end
    endcase
    next_err_level = (next_state == PD_LEAD);
    next_err_drive = (next_state != PD_MATCH);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state     <= PD_MATCH;
      err_level <= 1'b0;
      err_drive <= 1'b0;
    end else begin
      state     <= next_state;
      err_level <= next_err_level;
      err_drive <= next_err_drive;
    end
  end

  // Both pins share one flop pair so they cannot drift apart
  always_comb begin
    phase_error_out_a    = err_level;
    phase_error_out_b    = err_level;
    phase_error_out_a_oe = err_drive;
    phase_error_out_b_oe = err_drive;
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_div_first;
    state == PD_MATCH && div_pulse && !ref_pulse;
  endsequence

  sequence s_ref_first;
    state == PD_MATCH && ref_pulse && !div_pulse;
  endsequence

  // Lead kept: no lone reference tick to end it this cycle
  sequence s_lead_hold;
    state == PD_LEAD && !(ref_pulse && !div_pulse);
  endsequence

  // Lag kept: no lone divided pulse to end it this cycle
  sequence s_lag_hold;
    state == PD_LAG && !(div_pulse && !ref_pulse);
  endsequence

  chk_pins_identical: assert property (
    phase_error_out_a == phase_error_out_b && phase_error_out_a_oe == phase_error_out_b_oe)
    else $error("Error pins differ");

  chk_fast_drives_high: assert property (
    s_div_first |=> phase_error_out_a_oe && phase_error_out_a)
    else $error("Fast divided signal not driven high");

  chk_fast_holds_high: assert property (
    s_lead_hold |=> phase_error_out_a_oe && phase_error_out_a)
    else $error("Fast divided signal not held high");

  chk_slow_drives_low: assert property (
    s_ref_first |=> phase_error_out_a_oe && !phase_error_out_a)
    else $error("Slow divided signal not driven low");

  chk_slow_holds_low: assert property (
    s_lag_hold |=> phase_error_out_a_oe && !phase_error_out_a)
    else $error("Slow divided signal not held low");

  chk_match_floats: assert property (
    state == PD_MATCH && !div_pulse && !ref_pulse |=> !phase_error_out_a_oe)
    else $error("Pins driven while matched");

  chk_lead_order: assert property (
    s_div_first |=> state == PD_LEAD)
    else $error("Divided edge first did not give lead");

  chk_lag_release: assert property (
    state == PD_LAG && div_pulse && !ref_pulse |=> state == PD_MATCH ##0 !err_drive)
    else $error("Lag not released by divided edge");

  chk_fm_swallow_only: assert property (
    cfg.osc_sel == OSC_SEL_FM && osc_edge && pre_cnt < pre_last |=> !div_pulse)
    else $error("FM input divided without prescaler");

  chk_direct_ratio: assert property (
    !swallow_mode && osc_edge && main_last |=> div_pulse && main_cnt == DIV_ZERO)
    else $error("Direct division missed its count");

  chk_ref_tick: assert property (
    ref_pulse |=> !ref_pulse)
    else $error("Reference tick wider than one cycle");

endmodule // pll_phase_comparator

`default_nettype wire

/* File: rtl/pll_pkg.sv */
// Constants, types and states for the synthesizer phase-comparison stage.
// Assumes one system clock mclk at 125 MHz, and configuration driven by
// logic on that same clock.
//
// Operation
// - FM oscillator input is divided by pulse swallow only, never directly.
// - AM oscillator input is divided directly or by pulse swallow, as selected.
// - Divided oscillator phase is compared against the reference frequency.
// - Divided frequency above reference drives both error outputs high.
// - Divided frequency below reference drives both error outputs low.
// - Matched frequencies release the error outputs to high impedance.
// - Both error outputs always carry the identical waveform.
package pll_pkg;

  // ************************************************************
  // Clock and widths
  // ************************************************************
  localparam int MCLK_HZ    = 125_000_000;
  localparam int REF_HZ_DEF = 5_000;
  localparam int DIV_W      = 16;
  localparam int SWALLOW_W  = 7;
  localparam int PRE_W      = 6;
  localparam int REF_W      = 24;

  // ************************************************************
  // Input choice and small constants
  // ************************************************************
  localparam logic OSC_SEL_FM = 1'b0;
  localparam logic OSC_SEL_AM = 1'b1;

  localparam logic [DIV_W-1:0]     DIV_ONE  = 16'h0001;
  localparam logic [DIV_W-1:0]     DIV_ZERO = 16'h0000;
  localparam logic [SWALLOW_W-1:0] SW_ONE   = 7'h01;
  localparam logic [SWALLOW_W-1:0] SW_ZERO  = 7'h00;
  localparam logic [PRE_W-1:0]     PRE_ONE  = 6'h01;
  localparam logic [PRE_W-1:0]     PRE_ZERO = 6'h00;
  localparam logic [REF_W-1:0]     REF_ONE  = 24'h000001;
  localparam logic [REF_W-1:0]     REF_ZERO = 24'h000000;

  // ************************************************************
  // Configuration carrier
  // ************************************************************
  typedef struct packed {
    logic                 osc_sel;     // FM or AM input
    logic                 am_direct;   // AM only: direct division
    logic [PRE_W-1:0]     prescale;    // Prescaler modulus P (P+1 while swallowing)
    logic [DIV_W-1:0]     main_div;    // Main divide ratio N
    logic [SWALLOW_W-1:0] swallow;     // Swallow count A
  } synth_cfg_s;

  // ************************************************************
  // Phase detector states
  // ************************************************************
  typedef enum logic [2:0] {
    PD_MATCH = 3'b001,
    PD_LEAD  = 3'b010,
    PD_LAG   = 3'b100
  } pd_state_e;

endpackage
